/* verilog/ccd_map.svh */
/*
  Constants for the call/clear/decrement execution unit: opcode patterns,
  field positions, reset values and cycle counts.
  Assumes 14-bit instruction words and an 8-bit data path.
*/
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

`define CCD_OP_CALL_MASK   14'h3800
`define CCD_OP_CALL_VAL    14'h2000
`define CCD_OP_KICK        14'h0064
`define CCD_OP_ACCUM_CLEAR_OP_MASK   14'h3F80
`define CCD_OP_ACCUM_CLEAR_OP_VAL    14'h0100
`define CCD_OP_ALU_MASK    14'h3F00
`define CCD_OP_FILE_CLEAR_OP_MASK   14'h3F80
`define CCD_OP_FILE_CLEAR_OP_VAL    14'h0180
`define CCD_OP_FILE_INVERT_OP_VAL    14'h0900
`define CCD_OP_FILE_DECREMENT_OP_VAL    14'h0300
`define CCD_OP_DECREMENT_SKIP_ZERO_OP_VAL  14'h0B00

`define CCD_K_MSB          10
`define CCD_F_MSB          6
`define CCD_D_BIT          7
`define CCD_LATCH_LO       3
`define CCD_LATCH_HI       4

`define CCD_PC_RESET       13'h0000
`define CCD_W_RESET        8'h00
`define CCD_ZERO_BYTE      8'h00
`define CCD_BRANCH_CYCLES  2

`endif

/* verilog/ccd_pkg.sv */
/*
  Types for the call/clear/decrement execution unit.
  Assumes ccd_map.svh is compiled alongside.
*/
package ccd_pkg;
  typedef enum logic [2:0] {
    CCD_NONE, CCD_CALL, CCD_KICK, CCD_FILE_CLEAR_OP, CCD_FILE_INVERT_OP, CCD_ACCUM_CLEAR_OP, CCD_FILE_DECREMENT_OP, CCD_DECREMENT_SKIP_ZERO_OP
  } ccd_op_type;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } ccd_file_wr_type;

  typedef struct packed {
    logic        push;
    logic [12:0] addr;
  } ccd_stack_push_type;
endpackage

/* verilog/ccd_exec.sv */
/*
  Execution unit for call, watchdog kick, file/accumulator clear, complement,
  decrement and decrement-skip-on-zero. One instruction is offered per cycle.
  Assumes the file register read data for file_rd_addr is valid in the same cycle
  and that the stack, watchdog and file memory live outside.
*/
// Notes on behaviour
// - Call pushes PC plus one onto the return stack top.
// - Call loads the eleven-bit immediate into PC bits 10..0.
// - Call fills PC bits 12..11 from latch bits 4..3.
// - Call takes two instruction cycles.
// - Watchdog kick clears the watchdog count and its prescaler.
// - Watchdog kick sets expiry and power-down flags, nothing else.
// - File clear writes zero to the register and sets the zero flag.
// - Complement inverts the register into accumulator or register, updating zero flag.
// - Accumulator clear writes zero to the accumulator and sets zero flag.
// - Decrement subtracts one into accumulator or register, updating zero flag.
// - Decrement-skip stores result per destination; nonzero continues normally.
// - Decrement-skip to zero discards the fetched instruction, two cycles.
`include "ccd_map.svh"

module ccd_exec (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Instruction in
  input  wire logic                        instr_valid,
  input  wire logic [13:0]                 instr_word,
  input  wire logic [7:0]                  file_rd_data,
  input  wire logic [7:0]                  pc_high_latch,
  // Instruction flow
  output logic                             instr_ready,
  output logic [6:0]                       file_rd_addr,
  output logic [12:0]                      pc,
  output logic                             flush,
  // Results
  output ccd_pkg::ccd_file_wr_type         file_wr,
  output ccd_pkg::ccd_stack_push_type      stack_top_push,
  output logic [7:0]                       accum,
  output logic                             result_null_flag,
  output logic                             watchdog_expiry_flag,
  output logic                             power_down_flag,
  output logic                             watchdog_clear
);

  typedef enum logic {CCD_RUN, CCD_SECOND} ccd_state_type;

  ccd_state_type       state;
  ccd_pkg::ccd_op_type op;
  logic                dest_file;
  logic [7:0]          dec_result;
  logic [7:0]          inv_result;
  logic                take;

  function automatic ccd_pkg::ccd_op_type ccd_decode(input logic [13:0] w);
    if ((w & `CCD_OP_CALL_MASK) == `CCD_OP_CALL_VAL)
      return ccd_pkg::CCD_CALL;
    if (w == `CCD_OP_KICK)
      return ccd_pkg::CCD_KICK;
    if ((w & `CCD_OP_FILE_CLEAR_OP_MASK) == `CCD_OP_FILE_CLEAR_OP_VAL)
      return ccd_pkg::CCD_FILE_CLEAR_OP;
    if ((w & `CCD_OP_ACCUM_CLEAR_OP_MASK) == `CCD_OP_ACCUM_CLEAR_OP_VAL)
      return ccd_pkg::CCD_ACCUM_CLEAR_OP;
    if ((w & `CCD_OP_ALU_MASK) == `CCD_OP_FILE_INVERT_OP_VAL)
      return ccd_pkg::CCD_FILE_INVERT_OP;
    if ((w & `CCD_OP_ALU_MASK) == `CCD_OP_FILE_DECREMENT_OP_VAL)
      return ccd_pkg::CCD_FILE_DECREMENT_OP;
    if ((w & `CCD_OP_ALU_MASK) == `CCD_OP_DECREMENT_SKIP_ZERO_OP_VAL)
      return ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP;
    return ccd_pkg::CCD_NONE;
  endfunction

  // Second cycle of a two-cycle instruction accepts nothing new
  assign instr_ready  = (state == CCD_RUN);
  assign take         = instr_valid && instr_ready;
  assign op           = ccd_decode(instr_word);
  assign dest_file    = instr_word[`CCD_D_BIT];
  assign file_rd_addr = instr_word[`CCD_F_MSB:0];
  assign dec_result   = file_rd_data - 8'h01;
  assign inv_result   = ~file_rd_data;

  // Two-cycle sequencing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= CCD_RUN;
    end else begin
      unique case (state)
        CCD_RUN: begin
          if (take && op == ccd_pkg::CCD_CALL)
            state <= CCD_SECOND;
          else if (take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && dec_result == `CCD_ZERO_BYTE)
            state <= CCD_SECOND;
        end
        CCD_SECOND: state <= CCD_RUN;
      endcase
    end
  end

  // Flush marks the cycle whose fetched word is replaced by a no-operation
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      flush <= 1'b0;
    else
      flush <= take && (op == ccd_pkg::CCD_CALL ||
               (op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && dec_result == `CCD_ZERO_BYTE));
  end

  // Program counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      pc <= `CCD_PC_RESET;
    else if (take && op == ccd_pkg::CCD_CALL)
      pc <= {pc_high_latch[`CCD_LATCH_HI:`CCD_LATCH_LO],
             instr_word[`CCD_K_MSB:0]};
    else if (take)
      pc <= pc + 13'h0001;
  end

  // Return stack push
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stack_top_push <= '0;
    end else begin
      stack_top_push.push <= take && op == ccd_pkg::CCD_CALL;
      stack_top_push.addr <= pc + 13'h0001;
    end
  end

  // File register write-back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      file_wr <= '0;
    end else begin
      file_wr.we   <= 1'b0;
      file_wr.addr <= instr_word[`CCD_F_MSB:0];
      file_wr.data <= `CCD_ZERO_BYTE;
      if (take) begin
        unique case (op)
          ccd_pkg::CCD_FILE_CLEAR_OP: file_wr.we <= 1'b1;
          ccd_pkg::CCD_FILE_INVERT_OP: begin
            file_wr.we   <= dest_file;
            file_wr.data <= inv_result;
          end
          ccd_pkg::CCD_FILE_DECREMENT_OP, ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP: begin
            file_wr.we   <= dest_file;
            file_wr.data <= dec_result;
          end
          default: ;
        endcase
      end
    end
  end

  // Accumulator
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accum <= `CCD_W_RESET;
    end else if (take) begin
      unique case (op)
        ccd_pkg::CCD_ACCUM_CLEAR_OP: accum <= `CCD_ZERO_BYTE;
        ccd_pkg::CCD_FILE_INVERT_OP: if (!dest_file) accum <= inv_result;
        ccd_pkg::CCD_FILE_DECREMENT_OP, ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP: if (!dest_file) accum <= dec_result;
        default: ;
      endcase
    end
  end

  // Zero flag; call and decrement-skip leave it alone
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      result_null_flag <= 1'b0;
    end else if (take) begin
      unique case (op)
        ccd_pkg::CCD_FILE_CLEAR_OP, ccd_pkg::CCD_ACCUM_CLEAR_OP: result_null_flag <= 1'b1;
        ccd_pkg::CCD_FILE_INVERT_OP: result_null_flag <= (inv_result == `CCD_ZERO_BYTE);
        ccd_pkg::CCD_FILE_DECREMENT_OP: result_null_flag <= (dec_result == `CCD_ZERO_BYTE);
        default: ;
      endcase
    end
  end

  // Watchdog kick; both flags reset to one as after power-up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      watchdog_expiry_flag <= 1'b1;
      power_down_flag      <= 1'b1;
      watchdog_clear       <= 1'b0;
    end else begin
      watchdog_clear <= take && op == ccd_pkg::CCD_KICK;
      if (take && op == ccd_pkg::CCD_KICK) begin
        watchdog_expiry_flag <= 1'b1;
        power_down_flag      <= 1'b1;
      end
    end
  end

  logic take_q;
  ccd_pkg::ccd_op_type op_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      take_q <= 1'b0;
      op_q   <= ccd_pkg::CCD_NONE;
    end else begin
      take_q <= take;
      op_q   <= op;
    end
  end

  AST_CALL_PUSH: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_CALL |=> stack_top_push.push && stack_top_push.addr == $past(pc) + 13'h0001)
    else $error("call did not push return address");
  AST_CALL_PC: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_CALL |=> pc[10:0] == $past(instr_word[10:0]))
    else $error("call target low bits wrong");
  AST_CALL_HI: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_CALL |=> pc[12:11] == $past(pc_high_latch[4:3]))
    else $error("call target high bits wrong");
  AST_CALL_TWO: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_CALL |=> !instr_ready ##1 instr_ready)
    else $error("call not two cycles");
  AST_KICK: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_KICK |=> watchdog_clear && watchdog_expiry_flag && power_down_flag)
    else $error("kick failed");
  AST_KICK_Z: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_KICK |=> $stable(result_null_flag) && $stable(accum))
    else $error("kick changed other state");
  AST_FILE_CLEAR_OP: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_CLEAR_OP |=> file_wr.we && file_wr.data == 8'h00 && result_null_flag)
    else $error("file clear wrong");
  AST_FILE_INVERT_OP: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_INVERT_OP && !dest_file |=> accum == ~$past(file_rd_data) && !file_wr.we)
    else $error("complement wrong");
  AST_ACCUM_CLEAR_OP: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_ACCUM_CLEAR_OP |=> accum == 8'h00 && result_null_flag)
    else $error("accumulator clear wrong");
  AST_FILE_DECREMENT_OP: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_DECREMENT_OP && dest_file |=> file_wr.we && file_wr.data == $past(file_rd_data) - 8'h01)
    else $error("decrement wrong");
  AST_DSZ_GO: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && file_rd_data != 8'h01 |=> instr_ready && !flush)
    else $error("nonzero decrement skipped");
  AST_DSZ_SKIP: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && file_rd_data == 8'h01 |=> flush && !instr_ready)
    else $error("zero decrement did not skip");
  AST_NOFLAG: assert property (@(posedge clk_sys) disable iff (rst)
    take_q && (op_q == ccd_pkg::CCD_CALL || op_q == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP) |-> $stable(result_null_flag))
    else $error("flag changed");
  AST_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    file_rd_addr == instr_word[6:0])
    else $error("file address field wrong");

  // Call side effects; a stray push would corrupt the return stack
  AST_PUSH_SRC: assert property (@(posedge clk_sys) disable iff (rst)
    stack_top_push.push |-> $past(take && op == ccd_pkg::CCD_CALL))
    else $error("push without call");
  AST_PUSH_ONE: assert property (@(posedge clk_sys) disable iff (rst)
    stack_top_push.push |=> !stack_top_push.push)
    else $error("push longer than one cycle");
  AST_PC_STEP: assert property (@(posedge clk_sys) disable iff (rst)
    take && op != ccd_pkg::CCD_CALL |=> pc == $past(pc) + 13'h0001)
    else $error("program counter did not step");
  AST_CALL_FLUSH: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_CALL |=> flush)
    else $error("call did not flush");
  AST_DEAD_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !instr_ready |=> pc == $past(pc))
    else $error("program counter moved in dead cycle");
  AST_CALL_ACC: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_CALL |=> $stable(accum) && !file_wr.we)
    else $error("call touched data");

  // Watchdog kick
  AST_KICK_SRC: assert property (@(posedge clk_sys) disable iff (rst)
    watchdog_clear |-> $past(take && op == ccd_pkg::CCD_KICK))
    else $error("watchdog clear without kick");
  AST_KICK_ONE: assert property (@(posedge clk_sys) disable iff (rst)
    watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");
  AST_FLAGS_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !(take && op == ccd_pkg::CCD_KICK) |=> $stable(watchdog_expiry_flag) && $stable(power_down_flag))
    else $error("watchdog flags moved without kick");
  AST_KICK_NOWR: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_KICK |=> !file_wr.we && !stack_top_push.push)
    else $error("kick wrote data");

  // Clears
  AST_FILE_CLEAR_OP_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_CLEAR_OP |=> file_wr.addr == $past(instr_word[6:0]) && $stable(accum))
    else $error("file clear address wrong");
  AST_ACCUM_CLEAR_OP_NOWR: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_ACCUM_CLEAR_OP |=> !file_wr.we)
    else $error("accumulator clear wrote register");

  // Complement
  AST_FILE_INVERT_OP_REG: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_INVERT_OP && dest_file |=> file_wr.we && file_wr.data == ~$past(file_rd_data))
    else $error("complement to register wrong");
  AST_FILE_INVERT_OP_Z: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_INVERT_OP |=> result_null_flag == ($past(file_rd_data) == 8'hFF))
    else $error("complement zero flag wrong");

  // Decrement; 00h wraps to FFh with no carry out
  AST_FILE_DECREMENT_OP_ACC: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_DECREMENT_OP && !dest_file |=> accum == $past(file_rd_data) - 8'h01 && !file_wr.we)
    else $error("decrement to accumulator wrong");
  AST_FILE_DECREMENT_OP_Z: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_DECREMENT_OP |=> result_null_flag == ($past(file_rd_data) == 8'h01))
    else $error("decrement zero flag wrong");
  AST_FILE_DECREMENT_OP_GO: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_FILE_DECREMENT_OP |=> !flush && instr_ready)
    else $error("plain decrement skipped");
  AST_DSZ_REG: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && dest_file |=> file_wr.we && file_wr.data == $past(file_rd_data) - 8'h01)
    else $error("decrement-skip to register wrong");
  AST_DSZ_ACC: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && !dest_file |=> accum == $past(file_rd_data) - 8'h01)
    else $error("decrement-skip to accumulator wrong");

  // Skip timing
  AST_FLUSH_ONE: assert property (@(posedge clk_sys) disable iff (rst)
    flush |=> !flush)
    else $error("flush longer than one cycle");
  AST_FLUSH_DEAD: assert property (@(posedge clk_sys) disable iff (rst)
    flush |-> !instr_ready)
    else $error("flush while accepting");
  AST_DSZ_PC: assert property (@(posedge clk_sys) disable iff (rst)
    take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && file_rd_data == 8'h01 |=>
      pc == $past(pc) + 13'h0001 ##1 pc == $past(pc, 2) + 13'h0001)
    else $error("skip cycle moved program counter");

  // Write-back address always from the operand field
  AST_WR_ADDR: assert property (@(posedge clk_sys) disable iff (rst)
    file_wr.we |-> file_wr.addr == $past(instr_word[6:0]))
    else $error("write-back address wrong");


  COV_CALL: cover property (@(posedge clk_sys) disable iff (rst) take && op == ccd_pkg::CCD_CALL);
  COV_SKIP: cover property (@(posedge clk_sys) disable iff (rst) take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && file_rd_data == 8'h01);
  COV_KICK: cover property (@(posedge clk_sys) disable iff (rst) take && op == ccd_pkg::CCD_KICK);
  COV_FILE_INVERT_OP: cover property (@(posedge clk_sys) disable iff (rst) take && op == ccd_pkg::CCD_FILE_INVERT_OP && dest_file);
  COV_DSZ_GO: cover property (@(posedge clk_sys) disable iff (rst) take && op == ccd_pkg::CCD_DECREMENT_SKIP_ZERO_OP && file_rd_data != 8'h01);

endmodule

/* tb/test_ccd_exec.sv */
/*
  Self-checking bench for the call/clear/decrement execution unit.
  Assumes ccd_pkg and ccd_exec are compiled first; the bench plays both
  the fetch stage and the file memory, one instruction per call.
*/
module test_ccd_exec;
  timeunit 1ns;
  timeprecision 100ps;

  logic                           clk_sys;
  logic                           rst;
  logic                           instr_valid;
  logic [13:0]                    instr_word;
  logic [7:0]                     file_rd_data;
  logic [7:0]                     pc_high_latch;
  logic                           instr_ready;
  logic [6:0]                     file_rd_addr;
  logic [12:0]                    pc;
  logic                           flush;
  ccd_pkg::ccd_file_wr_type       file_wr;
  ccd_pkg::ccd_stack_push_type    stack_top_push;
  logic [7:0]                     accum;
  logic                           result_null_flag;
  logic                           watchdog_expiry_flag;
  logic                           power_down_flag;
  logic                           watchdog_clear;
  int                             n_fail;
  int                             samples_checked;
  logic [12:0]                    exp_pc;
  logic                           exp_z;
  logic [7:0]                     latch_tab [2] = '{8'h18, 8'hF7};
  logic [10:0]                    k_tab [2] = '{11'h7FF, 11'h000};

  ccd_exec u_ccd_exec (
    .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
    .file_rd_data(file_rd_data), .pc_high_latch(pc_high_latch), .instr_ready(instr_ready),
    .file_rd_addr(file_rd_addr), .pc(pc), .flush(flush), .file_wr(file_wr),
    .stack_top_push(stack_top_push), .accum(accum), .result_null_flag(result_null_flag),
    .watchdog_expiry_flag(watchdog_expiry_flag), .power_down_flag(power_down_flag),
    .watchdog_clear(watchdog_clear)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One accepted instruction; returns just after the answer lands
  task automatic exec(input logic [13:0] w, input logic [7:0] d);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    file_rd_data <= d;
    #1 chk("file_rd_addr", 16'(w[6:0]), 16'(file_rd_addr));
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    exp_pc = exp_pc + 13'h0001;
    // A call lands on its target, checked by the caller
    #1 if (w[13:11] != 3'b100) chk("pc", 16'(exp_pc), 16'(pc));
  endtask

  // Pulses must drop after one cycle and the pipe must be open again
  task automatic quiet();
    @(posedge clk_sys);
    #1 chk("pulses", 16'h0000, 16'({file_wr.we, stack_top_push.push, flush, watchdog_clear}));
    chk("instr_ready", 16'h0001, 16'(instr_ready));
  endtask

  task automatic res(input logic [7:0] acc, input logic z, input logic we, input logic [14:0] wr);
    chk("accum", 16'(acc), 16'(accum));
    chk("result_null_flag", 16'(z), 16'(result_null_flag));
    chk("file_wr.we", 16'(we), 16'(file_wr.we));
    if (we) chk("file_wr", 16'(wr), 16'({file_wr.addr, file_wr.data}));
  endtask

  initial begin
    #20000;
    n_fail++;
    complete_run();
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    exp_pc = 13'h0000;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    file_rd_data = 8'h00;
    pc_high_latch = 8'h00;
    repeat (3) @(posedge clk_sys);
    #1 res(8'h00, 1'b0, 1'b0, 15'h0000);
    chk("flags_rst", 16'h0003, 16'({watchdog_expiry_flag, power_down_flag}));
    rst <= 1'b0;
    exec(14'h0064, 8'h00);
    chk("watchdog_clear", 16'h0001, 16'(watchdog_clear));
    chk("flags_kick", 16'h0003, 16'({watchdog_expiry_flag, power_down_flag}));
    quiet();
    exec(14'h0905, 8'h5A);
    res(8'hA5, 1'b0, 1'b0, 15'h0000);
    exec(14'h0100, 8'h77);
    res(8'h00, 1'b1, 1'b0, 15'h0000);
    exec(14'h0985, 8'h0F);
    res(8'h00, 1'b0, 1'b1, {7'h05, 8'hF0});
    exec(14'h01FF, 8'h3C);
    res(8'h00, 1'b1, 1'b1, {7'h7F, 8'h00});
    exec(14'h0383, 8'h00);
    res(8'h00, 1'b0, 1'b1, {7'h03, 8'hFF});
    exec(14'h0303, 8'h01);
    res(8'h00, 1'b1, 1'b0, 15'h0000);
    exec(14'h0B89, 8'h02);
    res(8'h00, 1'b1, 1'b1, {7'h09, 8'h01});
    chk("flush_nz", 16'h0001, 16'({flush, instr_ready}));
    exec(14'h0383, 8'h02);
    exec(14'h0B09, 8'h01);
    res(8'h00, 1'b0, 1'b0, 15'h0000);
    chk("flush_z", 16'h0002, 16'({flush, instr_ready}));
    quiet();
    exp_z = 1'b0;
    for (int i = 0; i < 2; i++) begin
      pc_high_latch <= latch_tab[i];
      exec({3'b100, k_tab[i]}, 8'h00);
      chk("push", 16'({1'b1, exp_pc}), 16'(stack_top_push));
      exp_pc = {latch_tab[i][4:3], k_tab[i]};
      chk("pc_call", 16'(exp_pc), 16'(pc));
      chk("flush_call", 16'h0002, 16'({flush, instr_ready}));
      chk("z_call", 16'(exp_z), 16'(result_null_flag));
      // Offered in the dead cycle: must be taken only once
      instr_valid <= 1'b1;
      instr_word <= 14'h0100;
      @(posedge clk_sys);
      #1 chk("z_dead", 16'(exp_z), 16'(result_null_flag));
      chk("pc_dead", 16'(exp_pc), 16'(pc));
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      exp_pc = exp_pc + 13'h0001;
      exp_z = 1'b1;
      #1 chk("pc_after", 16'(exp_pc), 16'(pc));
      chk("z_after", 16'h0001, 16'(result_null_flag));
    end
    quiet();
    complete_run();
  end
endmodule
